// file: design/ofd_decoder.sv
// Opcode field decoder: condition, register selects, label, swap codes.
// Assumes fields arrive synchronous to clk_sys and a classic Wishbone master.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "ofd_defs.svh"

// Behaviour
// RULE1 - Condition groups 000 to 101 test the source register for equal, unequal, negative, non-positive, positive, non-negative.
// RULE2 - Codes 110 test overflow of the chosen accumulator, test flag one, test flag two or carry for one.
// RULE3 - Codes 111 00SS are true when the chosen accumulator overflow flag is zero.
// RULE4 - Codes 111 0100 to 111 0110 are true when flag one, flag two or carry is zero, and 111 0111 is reserved.
// RULE5 - Codes 110 10xx, 111 10xx and 111 11xx give AND, OR and XOR of the flags with per-bit inversion, 110 11xx reserved.
// RULE6 - The temporary destination selector picks temporary registers zero to three in order.
// RULE7 - The accumulator destination selector picks accumulators zero to three in order.
// RULE8 - The data label is an absolute address cut to the width the instruction format gives.
// RULE9 - The parallel-run bit is cleared at 0 and set at 1.
// RULE10 - General codes 0000 to 0011 pick accumulators and 0100 to 0111 pick temporary registers.
// RULE11 - General codes 1000 to 1111 pick auxiliary registers zero to seven for source and destination.
// RULE12 - The forty-bit option bit forces wide mode for that instruction, else the global setting holds.
// RULE13 - Swap codes 00 xxxx and 11 1000 exchange the listed single registers.
// RULE14 - Swap codes for pairs and the block exchange groups, and all other codes are invalid opcodes.
module ofd_decoder #(
  parameter int LABEL_W = 24,
  parameter int SRC_W = 40,
  parameter int LBITS_W = $clog2(LABEL_W + 1)
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire ofd_pkg::ofd_wb_req_t wb_req, // Bus request
  output ofd_pkg::ofd_wb_rsp_t wb_rsp, // Bus answer
  input wire ofd_pkg::ofd_instr_t instr, // Instruction fields
  input wire ofd_pkg::ofd_flags_t flags, // Status flags
  input wire logic signed [SRC_W-1:0] src_value, // Tested source value
  input wire logic [LABEL_W-1:0] abs_data_label, // Raw label bits
  input wire logic [LBITS_W-1:0] label_bits, // Label width of format
  output ofd_pkg::ofd_dec_t dec, // Decoded fields
  output logic [LABEL_W-1:0] label_addr // Absolute data address
);
  import ofd_pkg::*;

  generate
    if (LABEL_W < 1 || LABEL_W > 32 || SRC_W < 2) begin : g_bad
      $error("ofd_decoder: unsupported parameter values");
    end
  endgenerate

  function automatic ofd_reg_sel_t gp_decode(input logic [3:0] code);
    ofd_reg_sel_t r;
    r = '0;
    r.idx = code[2:0];
    if (code[`OFD_GP_AUX_BIT]) begin
      r.is_aux = 1'b1;
    end else if (code[`OFD_GP_TMP_BIT]) begin
      r.is_tmp = 1'b1;
      r.idx = {1'b0, code[1:0]};
    end else begin
      r.is_acc = 1'b1;
      r.idx = {1'b0, code[1:0]};
    end
    return r;
  endfunction

  logic ctrl_wide_q;
  logic [2:0] status_q;
  logic ack_q;
  logic [31:0] rdat_q;
  ofd_dec_t dec_q, dec_d;
  logic [LABEL_W-1:0] label_q, label_d;
  logic c_true, c_rsvd, f1, f2;
  logic [2:0] grp;
  logic [3:0] lo;
  logic bus_req, wr_en;
  logic [`OFD_ADR_BITS-1:0] adr_lo;

  // Condition evaluation
  always_comb begin
    grp = instr.cond_code[6:4];
    lo = instr.cond_code[3:0];
    f1 = flags.test_cond_flag_one ^ lo[1];
    f2 = flags.test_cond_flag_two ^ lo[0];
    c_true = 1'b0;
    c_rsvd = 1'b0;
    case (grp)
      `OFD_CC_EQ: c_true = (src_value == '0); // RULE1
      `OFD_CC_NE: c_true = (src_value != '0); // RULE1
      `OFD_CC_LT: c_true = (src_value < 0); // RULE1
      `OFD_CC_LE: c_true = (src_value <= 0); // RULE1
      `OFD_CC_GT: c_true = (src_value > 0); // RULE1
      `OFD_CC_GE: c_true = (src_value >= 0); // RULE1
      `OFD_CC_SET: begin
        if (lo[3:2] == `OFD_LO_OVF) begin
          c_true = flags.acc_ovf_flag[lo[1:0]]; // RULE2
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_TC1}) begin
          c_true = flags.test_cond_flag_one; // RULE2
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_TC2}) begin
          c_true = flags.test_cond_flag_two; // RULE2
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_CARRY}) begin
          c_true = flags.carry; // RULE2
        end else if (lo[3:2] == `OFD_LO_AND) begin
          c_true = f1 & f2; // RULE5
        end else begin
          c_rsvd = 1'b1; // RULE5
        end
      end
      default: begin
        if (lo[3:2] == `OFD_LO_OVF) begin
          c_true = !flags.acc_ovf_flag[lo[1:0]]; // RULE3
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_TC1}) begin
          c_true = !flags.test_cond_flag_one; // RULE4
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_TC2}) begin
          c_true = !flags.test_cond_flag_two; // RULE4
        end else if (lo == {`OFD_LO_FLG, `OFD_FLG_CARRY}) begin
          c_true = !flags.carry; // RULE4
        end else if (lo[3:2] == `OFD_LO_AND) begin
          c_true = f1 | f2; // RULE5
        end else if (lo[3:2] == `OFD_LO_XOR) begin
          c_true = f1 ^ f2; // RULE5
        end else begin
          c_rsvd = 1'b1; // RULE4
        end
      end
    endcase
  end

  // Field decode
  always_comb begin
    dec_d = '0;
    dec_d.valid = instr.valid;
    dec_d.cond_true = c_true & ~c_rsvd;
    dec_d.cond_rsvd = c_rsvd;
    dec_d.tmp_dst = `OFD_ONE4 << instr.tmp_dst_sel; // RULE6
    dec_d.acc_dst = `OFD_ONE4 << instr.acc_dst_sel; // RULE7
    dec_d.gp_src = gp_decode(instr.gp_src_code); // RULE10 RULE11
    dec_d.gp_dst = gp_decode(instr.gp_dst_code); // RULE10 RULE11
    dec_d.par_en = instr.par_bit; // RULE9
    dec_d.wide_acc_mode = instr.wide_opt | ctrl_wide_q; // RULE12
    dec_d.swap_len = `OFD_LEN_ONE;
    case (instr.swap_sel)
      `OFD_SW_AC02: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AC0, `OFD_R_AC2}; // RULE13
      `OFD_SW_AC13: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AC1, `OFD_R_AC3}; // RULE13
      `OFD_SW_T02: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_T0, `OFD_R_T2}; // RULE13
      `OFD_SW_T13: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_T1, `OFD_R_T3}; // RULE13
      `OFD_SW_AR02: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR0, `OFD_R_AR2}; // RULE13
      `OFD_SW_AR13: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR1, `OFD_R_AR3}; // RULE13
      `OFD_SW_AR4T0: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR4, `OFD_R_T0}; // RULE13
      `OFD_SW_AR5T1: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR5, `OFD_R_T1}; // RULE13
      `OFD_SW_AR6T2: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR6, `OFD_R_T2}; // RULE13
      `OFD_SW_AR7T3: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR7, `OFD_R_T3}; // RULE13
      `OFD_SW_AR01: {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR0, `OFD_R_AR1}; // RULE13
      `OFD_SW_P_AC02: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AC0, `OFD_R_AC2}; // RULE14
        dec_d.swap_len = `OFD_LEN_PAIR;
      end
      `OFD_SW_P_T02: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_T0, `OFD_R_T2}; // RULE14
        dec_d.swap_len = `OFD_LEN_PAIR;
      end
      `OFD_SW_P_AR02: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR0, `OFD_R_AR2}; // RULE14
        dec_d.swap_len = `OFD_LEN_PAIR;
      end
      `OFD_SW_P_AR4T0: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR4, `OFD_R_T0}; // RULE14
        dec_d.swap_len = `OFD_LEN_PAIR;
      end
      `OFD_SW_P_AR6T2: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR6, `OFD_R_T2}; // RULE14
        dec_d.swap_len = `OFD_LEN_PAIR;
      end
      `OFD_SW_B_AR4T0: begin
        {dec_d.swap_a, dec_d.swap_b} = {`OFD_R_AR4, `OFD_R_T0}; // RULE14
        dec_d.swap_len = `OFD_LEN_BLOCK;
      end
      default: begin
        dec_d.swap_len = `OFD_LEN_NONE;
        dec_d.swap_invalid = 1'b1; // RULE14
      end
    endcase
    // Only bits within the format's label width survive
    label_d = abs_data_label & ~({LABEL_W{1'b1}} << label_bits); // RULE8
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dec_q <= '0;
      label_q <= '0;
    end else begin
      dec_q <= dec_d;
      label_q <= label_d;
    end
  end

  assign dec = dec_q;
  assign label_addr = label_q;

  // Wishbone slave, one wait state per access
  assign bus_req = wb_req.cyc & wb_req.stb & ~ack_q;
  // Writes land at the edge where the master takes ack
  assign wr_en = wb_req.cyc & wb_req.stb & ack_q & wb_req.we & wb_req.sel[0];
  assign adr_lo = wb_req.adr[`OFD_ADR_BITS-1:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= bus_req;
      rdat_q <= '0;
      if (bus_req && !wb_req.we) begin
        if (adr_lo == `OFD_ADR_CTRL && wb_req.adr[31:`OFD_ADR_BITS] == '0) begin
          rdat_q <= {31'h0, ctrl_wide_q};
        end else if (adr_lo == `OFD_ADR_STATUS && wb_req.adr[31:`OFD_ADR_BITS] == '0) begin
          rdat_q <= {29'h0, status_q};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_wide_q <= `OFD_CTRL_RST;
    end else if (wr_en && adr_lo == `OFD_ADR_CTRL && wb_req.adr[31:`OFD_ADR_BITS] == '0) begin
      ctrl_wide_q <= wb_req.dat[`OFD_CTRL_WIDE];
    end
  end

  // Sticky bits clear on write of one; a new event wins over the clear
  logic [1:0] st_clr, st_set;
  always_comb begin
    st_clr = '0;
    if (wr_en && adr_lo == `OFD_ADR_STATUS && wb_req.adr[31:`OFD_ADR_BITS] == '0) begin
      st_clr = wb_req.dat[`OFD_ST_SINV:`OFD_ST_CRSV];
    end
    st_set = {dec_d.valid & dec_d.swap_invalid, dec_d.valid & dec_d.cond_rsvd};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_q <= `OFD_ST_RST;
    end else begin
      status_q[`OFD_ST_SINV:`OFD_ST_CRSV] <= (status_q[`OFD_ST_SINV:`OFD_ST_CRSV] & ~st_clr) | st_set;
      if (dec_d.valid) begin
        status_q[`OFD_ST_LAST] <= dec_d.cond_true;
      end
    end
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdat_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_COND_SRC: assert property ( // RULE1
    instr.cond_code[6:4] == `OFD_CC_LE |=> dec.cond_true == ($past(src_value) <= 0))
    else $error("non-positive test wrong");
  AST_COND_SET: assert property ( // RULE2
    instr.cond_code == {`OFD_CC_SET, `OFD_LO_FLG, `OFD_FLG_CARRY} |=> dec.cond_true == $past(flags.carry))
    else $error("carry set test wrong");
  AST_COND_NOVF: assert property ( // RULE3
    instr.cond_code[6:2] == {`OFD_CC_CLR, `OFD_LO_OVF}
    |=> dec.cond_true == !$past(flags.acc_ovf_flag[instr.cond_code[1:0]]))
    else $error("overflow clear test wrong");
  AST_COND_NTC2: assert property ( // RULE4
    instr.cond_code == {`OFD_CC_CLR, `OFD_LO_FLG, `OFD_FLG_TC2} |=> dec.cond_true != $past(flags.test_cond_flag_two))
    else $error("flag two clear test wrong");
  AST_COND_XOR: assert property ( // RULE5
    instr.cond_code[6:2] == {`OFD_CC_CLR, `OFD_LO_XOR} |=> dec.cond_true ==
    $past(flags.test_cond_flag_one ^ flags.test_cond_flag_two ^ instr.cond_code[1] ^ instr.cond_code[0]))
    else $error("xor test wrong");
  AST_COND_RSVD: assert property ( // RULE5
    instr.cond_code[6:2] == {`OFD_CC_SET, `OFD_LO_XOR} |=> dec.cond_rsvd && !dec.cond_true)
    else $error("reserved code not flagged");
  AST_TMP_DST: assert property ( // RULE6
    1'b1 |=> dec.tmp_dst == (`OFD_ONE4 << $past(instr.tmp_dst_sel)))
    else $error("temporary select wrong");
  AST_ACC_DST: assert property ( // RULE7
    1'b1 |=> $onehot(dec.acc_dst) && dec.acc_dst[$past(instr.acc_dst_sel)])
    else $error("accumulator select wrong");
  AST_LABEL: assert property ( // RULE8
    label_bits == LBITS_W'(LABEL_W) |=> label_addr == $past(abs_data_label))
    else $error("label not passed whole");
  AST_PAR: assert property ( // RULE9
    instr.par_bit |=> dec.par_en)
    else $error("parallel bit lost");
  AST_GP_AUX: assert property ( // RULE11
    instr.gp_dst_code[`OFD_GP_AUX_BIT] |=> dec.gp_dst.is_aux && !dec.gp_dst.is_tmp
    && dec.gp_dst.idx == $past(instr.gp_dst_code[2:0]))
    else $error("aux select wrong");
  AST_GP_TMP: assert property ( // RULE10
    instr.gp_src_code[3:2] == 2'h1 |=> dec.gp_src.is_tmp && !dec.gp_src.is_acc)
    else $error("temporary general select wrong");
  AST_WIDE: assert property ( // RULE12
    !instr.wide_opt && !ctrl_wide_q && !wr_en |=> !dec.wide_acc_mode)
    else $error("wide mode forced without cause");
  AST_SWAP_AR01: assert property ( // RULE13
    instr.swap_sel == `OFD_SW_AR01 |=> dec.swap_a == `OFD_R_AR0 && dec.swap_b == `OFD_R_AR1 && !dec.swap_invalid)
    else $error("aux swap wrong");
  AST_SWAP_BLK: assert property ( // RULE14
    instr.swap_sel == `OFD_SW_B_AR4T0 |=> dec.swap_len == `OFD_LEN_BLOCK ##1 1'b1)
    else $error("block swap length wrong");
  AST_WB_ACK: assert property (
    wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus answer timing wrong");

  COV_SWAP_INV: cover property (instr.valid && instr.swap_sel == 6'h3c ##1 status_q[`OFD_ST_SINV]);
  COV_COND_AND: cover property (instr.valid && instr.cond_code == 7'h68 ##1 dec.cond_true);
  COV_WIDE_GLOBAL: cover property (ctrl_wide_q && !instr.wide_opt ##1 dec.wide_acc_mode);
endmodule

// file: design/ofd_defs.svh
// Constants for the opcode field decoder: bus offsets, field codes, resets.
// Assumes inclusion by bare name from the package and the decoder module.
`ifndef OFD_DEFS_SVH
`define OFD_DEFS_SVH
// Register byte offsets
`define OFD_ADR_CTRL 4'h0
`define OFD_ADR_STATUS 4'h4
`define OFD_ADR_BITS 4
// Register bit positions and resets
`define OFD_CTRL_WIDE 0
`define OFD_CTRL_RST 1'h0
`define OFD_ST_CRSV 0
`define OFD_ST_SINV 1
`define OFD_ST_LAST 2
`define OFD_ST_RST 3'h0
// Condition upper group
`define OFD_CC_EQ 3'h0
`define OFD_CC_NE 3'h1
`define OFD_CC_LT 3'h2
`define OFD_CC_LE 3'h3
`define OFD_CC_GT 3'h4
`define OFD_CC_GE 3'h5
`define OFD_CC_SET 3'h6
`define OFD_CC_CLR 3'h7
// Condition low nibble classes (bits 3:2) and flag picks (bits 1:0)
`define OFD_LO_OVF 2'h0
`define OFD_LO_FLG 2'h1
`define OFD_LO_AND 2'h2
`define OFD_LO_XOR 2'h3
`define OFD_FLG_TC1 2'h0
`define OFD_FLG_TC2 2'h1
`define OFD_FLG_CARRY 2'h2
// General register code layout
`define OFD_GP_AUX_BIT 3
`define OFD_GP_TMP_BIT 2
`define OFD_ONE4 4'h1
// Register codes in general register numbering
`define OFD_R_AC0 4'h0
`define OFD_R_AC1 4'h1
`define OFD_R_AC2 4'h2
`define OFD_R_AC3 4'h3
`define OFD_R_T0 4'h4
`define OFD_R_T1 4'h5
`define OFD_R_T2 4'h6
`define OFD_R_T3 4'h7
`define OFD_R_AR0 4'h8
`define OFD_R_AR1 4'h9
`define OFD_R_AR2 4'ha
`define OFD_R_AR3 4'hb
`define OFD_R_AR4 4'hc
`define OFD_R_AR5 4'hd
`define OFD_R_AR6 4'he
`define OFD_R_AR7 4'hf
// Swap selector codes
`define OFD_SW_AC02 6'h00
`define OFD_SW_AC13 6'h01
`define OFD_SW_T02 6'h04
`define OFD_SW_T13 6'h05
`define OFD_SW_AR02 6'h08
`define OFD_SW_AR13 6'h09
`define OFD_SW_AR4T0 6'h0c
`define OFD_SW_AR5T1 6'h0d
`define OFD_SW_AR6T2 6'h0e
`define OFD_SW_AR7T3 6'h0f
`define OFD_SW_P_AC02 6'h10
`define OFD_SW_P_T02 6'h14
`define OFD_SW_P_AR02 6'h18
`define OFD_SW_P_AR4T0 6'h1c
`define OFD_SW_P_AR6T2 6'h1e
`define OFD_SW_B_AR4T0 6'h2c
`define OFD_SW_AR01 6'h38
// Swap lengths in registers per side
`define OFD_LEN_NONE 3'h0
`define OFD_LEN_ONE 3'h1
`define OFD_LEN_PAIR 3'h2
`define OFD_LEN_BLOCK 3'h4
`endif

// file: design/ofd_pkg.sv
// Types shared by the opcode field decoder and its surroundings.
// Assumes ofd_defs.svh is on the include path.
`include "ofd_defs.svh"
package ofd_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ofd_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ofd_wb_rsp_t;
  typedef struct packed {
    logic valid;
    logic [6:0] cond_code;
    logic [1:0] tmp_dst_sel;
    logic [1:0] acc_dst_sel;
    logic [3:0] gp_src_code;
    logic [3:0] gp_dst_code;
    logic par_bit;
    logic wide_opt;
    logic [5:0] swap_sel;
  } ofd_instr_t;
  typedef struct packed {
    logic test_cond_flag_one;
    logic test_cond_flag_two;
    logic carry;
    logic [3:0] acc_ovf_flag;
  } ofd_flags_t;
  typedef struct packed {
    logic is_acc;
    logic is_tmp;
    logic is_aux;
    logic [2:0] idx;
  } ofd_reg_sel_t;
  typedef struct packed {
    logic valid;
    logic cond_true;
    logic cond_rsvd;
    logic [3:0] tmp_dst;
    logic [3:0] acc_dst;
    ofd_reg_sel_t gp_src;
    ofd_reg_sel_t gp_dst;
    logic par_en;
    logic wide_acc_mode;
    logic [3:0] swap_a;
    logic [3:0] swap_b;
    logic [2:0] swap_len;
    logic swap_invalid;
  } ofd_dec_t;
endpackage

// file: verif/ofd_fetch_model.sv
// Fetch-side partner: a decode-stage register presenting one instruction a clock.
// Assumes the bench supplies the next fields one cycle ahead, on clk_sys.
`timescale 1ns/1ns
module ofd_fetch_model (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire ofd_pkg::ofd_instr_t nxt_instr, // Next instruction fields
  input wire ofd_pkg::ofd_flags_t nxt_flags, // Next flag levels
  input wire logic signed [39:0] nxt_src, // Next tested value
  input wire logic [23:0] nxt_label, // Next raw label
  input wire logic [4:0] nxt_bits, // Next label width
  output ofd_pkg::ofd_instr_t instr, // Fields to decoder
  output ofd_pkg::ofd_flags_t flags, // Flags to decoder
  output logic signed [39:0] src_value, // Tested value to decoder
  output logic [23:0] abs_data_label, // Label to decoder
  output logic [4:0] label_bits // Label width to decoder
);
  import ofd_pkg::*;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      instr <= '0;
      flags <= '0;
      src_value <= '0;
      abs_data_label <= '0;
      label_bits <= '0;
    end else begin
      instr <= nxt_instr;
      flags <= nxt_flags;
      src_value <= nxt_src;
      abs_data_label <= nxt_label;
      label_bits <= nxt_bits;
    end
  end
endmodule

// file: verif/test_ofd_decoder.sv
// Self-checking bench for the opcode field decoder, random and swept fields.
// Assumes the decoder answers one cycle after sampling and a one-wait bus.
`timescale 1ns/1ns
module test_ofd_decoder;
  import ofd_pkg::*;
  logic clk_sys, reset, ctrl_m, armed, p_rst, p_ctrl;
  ofd_wb_req_t req;
  ofd_wb_rsp_t wb_rsp;
  ofd_instr_t n_i, instr, p_i;
  ofd_flags_t n_f, flags, p_f;
  logic signed [39:0] n_s, src_value, p_s;
  logic [23:0] n_l, abs_data_label, p_l, label_addr;
  logic [4:0] n_b, label_bits, p_b;
  ofd_dec_t dec;
  logic [31:0] rd;
  logic [1:0] ec;
  logic exp_last;
  int bad_count, checks_done;

  ofd_fetch_model u_ofd_fetch_model (.clk_sys(clk_sys), .reset(reset), .nxt_instr(n_i), .nxt_flags(n_f),
    .nxt_src(n_s), .nxt_label(n_l), .nxt_bits(n_b), .instr(instr), .flags(flags), .src_value(src_value),
    .abs_data_label(abs_data_label), .label_bits(label_bits));
  ofd_decoder #(.LABEL_W(24), .SRC_W(40)) u_ofd_decoder (.clk_sys(clk_sys), .reset(reset), .wb_req(req),
    .wb_rsp(wb_rsp), .instr(instr), .flags(flags), .src_value(src_value), .abs_data_label(abs_data_label),
    .label_bits(label_bits), .dec(dec), .label_addr(label_addr));

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Returns {reserved, true}
  function automatic logic [1:0] exp_cond(logic [6:0] c, ofd_flags_t f, logic signed [39:0] s);
    logic a, b, n, v;
    a = f.test_cond_flag_one ^ c[1];
    b = f.test_cond_flag_two ^ c[0];
    n = c[4];
    case (c[6:4])
      3'h0: return {1'b0, s == 0};
      3'h1: return {1'b0, s != 0};
      3'h2: return {1'b0, s < 0};
      3'h3: return {1'b0, s <= 0};
      3'h4: return {1'b0, s > 0};
      3'h5: return {1'b0, s >= 0};
      default: begin
        case (c[3:2])
          2'h0: v = f.acc_ovf_flag[c[1:0]] ^ n;
          2'h1: v = (c[1:0] == 2'h0 ? f.test_cond_flag_one : c[1:0] == 2'h1 ? f.test_cond_flag_two : f.carry) ^ n;
          2'h2: v = n ? (a | b) : (a & b);
          default: v = a ^ b;
        endcase
        if (c[3:0] == 4'h7 || (c[3:2] == 2'h3 && !n)) return 2'b10;
        return {1'b0, v};
      end
    endcase
  endfunction

  function automatic ofd_reg_sel_t exp_reg(logic [3:0] c);
    ofd_reg_sel_t r;
    r.is_acc = !c[3] && !c[2];
    r.is_tmp = !c[3] && c[2];
    r.is_aux = c[3];
    r.idx = c[3] ? c[2:0] : {1'b0, c[1:0]};
    return r;
  endfunction

  // Returns {invalid, len, a, b}
  function automatic logic [11:0] exp_swap(logic [5:0] k);
    case (k)
      6'h00: return 12'h102;
      6'h01: return 12'h113;
      6'h04: return 12'h146;
      6'h05: return 12'h157;
      6'h08: return 12'h18a;
      6'h09: return 12'h19b;
      6'h0c: return 12'h1c4;
      6'h0d: return 12'h1d5;
      6'h0e: return 12'h1e6;
      6'h0f: return 12'h1f7;
      6'h10: return 12'h202;
      6'h14: return 12'h246;
      6'h18: return 12'h28a;
      6'h1c: return 12'h2c4;
      6'h1e: return 12'h2e6;
      6'h2c: return 12'h4c4;
      6'h38: return 12'h189;
      default: return 12'h800;
    endcase
  endfunction

  // Compares each decode against the inputs sampled one edge earlier
  always @(negedge clk_sys) begin
    if (armed && p_rst) begin
      chk("dec in reset", 40'h0, {3'h0, dec});
      exp_last = 1'b0;
    end
    if (armed && !p_rst) begin
      chk("valid", p_i.valid, dec.valid);
      ec = exp_cond(p_i.cond_code, p_f, p_s);
      if (p_i.valid) exp_last = ec[0];
      chk("cond", ec, {dec.cond_rsvd, dec.cond_true});
      chk("tmp_dst", 4'h1 << p_i.tmp_dst_sel, dec.tmp_dst);
      chk("acc_dst", 4'h1 << p_i.acc_dst_sel, dec.acc_dst);
      chk("label", p_b >= 5'd24 ? p_l : p_l & ((24'h1 << p_b) - 24'h1), label_addr);
      chk("par_en", p_i.par_bit, dec.par_en);
      chk("gp_src", exp_reg(p_i.gp_src_code), dec.gp_src);
      chk("gp_dst", exp_reg(p_i.gp_dst_code), dec.gp_dst);
      chk("wide", p_i.wide_opt | p_ctrl, dec.wide_acc_mode);
      chk("swap", exp_swap(p_i.swap_sel), {dec.swap_invalid, dec.swap_len, dec.swap_a, dec.swap_b});
    end
    armed = 1'b1;
    p_rst = reset;
    p_ctrl = ctrl_m;
    p_i = instr;
    p_f = flags;
    p_s = src_value;
    p_l = abs_data_label;
    p_b = label_bits;
  end

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    r = wb_rsp.dat;
    if (w && a == 32'h0) ctrl_m = d[0];
    if (n >= 50) begin
      chk("bus ack", 40'h1, 40'h0);
      finish_test();
    end
    req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic step(input logic sweep, input logic [6:0] c);
    ofd_instr_t t;
    int r;
    t = ofd_instr_t'(28'($urandom()));
    r = $urandom_range(3);
    if (sweep) begin
      t.cond_code = c;
      t.swap_sel = c[5:0];
      t.gp_src_code = c[3:0];
      t.gp_dst_code = ~c[3:0];
    end
    n_i <= t;
    n_f <= ofd_flags_t'(7'($urandom()));
    n_s <= r == 0 ? 40'sd0 : r == 1 ? -40'sd1 : r == 2 ? 40'sd1 : 40'({$urandom(), $urandom()});
    n_l <= 24'($urandom());
    n_b <= 5'($urandom());
    @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    $display("ERROR watchdog expected done seen hang");
    bad_count++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    armed = 1'b0;
    exp_last = 1'b0;
    ctrl_m = 1'b0;
    req = '0;
    n_i = '0;
    n_f = '0;
    n_s = '0;
    n_l = '0;
    n_b = '0;
    void'($urandom(32'h5f7d));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    wb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl reset", 40'h0, rd);
    wb(1'b0, 32'h4, 32'h0, rd);
    chk("status reset", 40'h0, rd);
    wb(1'b1, 32'h0, 32'h1, rd);
    wb(1'b1, 32'h8, 32'h0, rd);
    wb(1'b0, 32'h8, 32'h0, rd);
    chk("unmapped read", 40'h0, rd);
    wb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl", 40'h1, rd);
    $display("test registers done");
    for (int i = 0; i < 128; i++) step(1'b1, 7'(i));
    for (int i = 0; i < 300; i++) step(1'b0, 7'h0);
    wb(1'b1, 32'h0, 32'h0, rd);
    for (int i = 0; i < 300; i++) step(1'b0, 7'h0);
    $display("test decode done");
    n_i <= '0;
    repeat (3) @(posedge clk_sys);
    wb(1'b1, 32'h4, 32'h7, rd);
    wb(1'b0, 32'h4, 32'h0, rd);
    chk("status cleared", {37'h0, exp_last, 2'b00}, rd);
    n_i <= '{valid: 1'b1, cond_code: 7'h77, swap_sel: 6'h3f, default: '0};
    @(posedge clk_sys);
    n_i <= '{valid: 1'b1, cond_code: 7'h64, default: '0};
    n_f <= '{test_cond_flag_one: 1'b1, default: '0};
    @(posedge clk_sys);
    n_i <= '0;
    repeat (3) @(posedge clk_sys);
    wb(1'b0, 32'h4, 32'h0, rd);
    chk("status events", 40'h7, rd);
    wb(1'b1, 32'h4, 32'h3, rd);
    wb(1'b0, 32'h4, 32'h0, rd);
    chk("status w1c", 40'h4, rd);
    $display("test status done");
    finish_test();
  end
endmodule
